// >>> hdl/tlsg_top.sv
// Torque limit and stall guard top: AXI4-Lite registers, torque clamp, stall guard.
// Assumes torque and current samples arrive on aclk; analog input already digitised in microamps.
`timescale 1ns/1ns
// Function
// RQ1: Torque limiting only in open-loop vector
// RQ2: Four quadrant limits, default 200 percent
// RQ3: Analog codes 10,11,12,15 select limit use
// RQ4: Analog 4-20 mA, 20 mA is 100%
// RQ5: Smallest of parameter, analog, duty ceiling
// RQ6: Forward analog limit also while regenerating
// RQ7: Suspend speed control while clamping
// RQ8: Analog limit scaled by input gain
// RQ9: Stall prevention only under V/f
// RQ10: Decel after 100 ms above level
// RQ11: Reaccel below level minus 2 percent
// RQ12: Select 0 off, 1 decel1, 2 decel2
// RQ13: Stall level 30 to 200, used if enabled
// RQ14: Level default 120 VT, 150 CT
// RQ15: Code 8 uses smaller analog/parameter level
// RQ16: Qualification timer restarts when current drops
// RQ17: Limits clamp torque as magnitudes
module tlsg_top import tlsg_pkg::*; #(
   parameter int QUAL_CYC = STALL_QUAL_CYC
) (
   input wire logic aclk,                // Clock 125 MHz
   input wire logic aresetn,             // Sync reset, active low
   input wire logic [7:0] s_axi_awaddr,  // Write address
   input wire logic s_axi_awvalid,       // Write address valid
   output logic s_axi_awready,           // Write address ready
   input wire logic [31:0] s_axi_wdata,  // Write data
   input wire logic [3:0] s_axi_wstrb,   // Write strobes
   input wire logic s_axi_wvalid,        // Write data valid
   output logic s_axi_wready,            // Write data ready
   output logic [1:0] s_axi_bresp,       // Write response
   output logic s_axi_bvalid,            // Write response valid
   input wire logic s_axi_bready,        // Write response ready
   input wire logic [7:0] s_axi_araddr,  // Read address
   input wire logic s_axi_arvalid,       // Read address valid
   output logic s_axi_arready,           // Read address ready
   output logic [31:0] s_axi_rdata,      // Read data
   output logic [1:0] s_axi_rresp,       // Read response
   output logic s_axi_rvalid,            // Read data valid
   input wire logic s_axi_rready,        // Read data ready
   input wire logic signed [15:0] torque_in,  // Internal torque, percent rated
   input wire logic regen,               // Motor regenerating
   input wire logic [15:0] current_in,   // Output current, percent rated
   input wire logic [15:0] analog_ua,    // Analog input, microamps
   output logic signed [15:0] torque_out, // Limited torque
   output logic speed_ctrl_hold,         // Suspend speed control
   output logic stall_decel,             // Lower output frequency
   output logic stall_accel,             // Reaccelerate
   output logic stall_use_decel_two      // Use second decel time
);
   tlsg_cfg_t cfg_q;
   tlsg_lims_t lims_q;
   logic [15:0] stall_lvl_q;
   logic [15:0] gain_q;
   logic stall_lvl_set_q;
   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic signed [15:0] torque_q;
   logic clamp_q;
   logic [15:0] ana_pct, par_lim, ceil_lim, eff_lim, stall_lvl_eff, stall_lvl_param, abs_t;
   logic [47:0] ana_prod;
   logic olv, fwd, use_ana, ana_ok;
   logic [15:0] wmerge, ctrl_rd;
   tlsg_state_t sg_state;

   // Write channel: capture address and data in either order
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready = !w_q && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (aw_q && w_q) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_bresp = 2'b00;

   // Byte-lane merge of the written word over the old low half
   function automatic logic [15:0] tlsg_merge(input logic [15:0] old);
      tlsg_merge = {wstrb_q[1] ? wdata_q[15:8] : old[15:8], wstrb_q[0] ? wdata_q[7:0] : old[7:0]};
   endfunction : tlsg_merge

   // Limit setting saturates at the top of its range
   function automatic logic [15:0] sat300(input logic [15:0] v);
      sat300 = (v > LIM_MAX) ? LIM_MAX : v;
   endfunction : sat300

   // Control word in its register layout, for readback and for the byte merge
   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[CTRL_METHOD_LSB +: 2] = cfg_q.method;
      ctrl_rd[CTRL_DUTY_BIT] = cfg_q.duty_vt;
      ctrl_rd[CTRL_SPS_LSB +: 2] = cfg_q.sps;
      ctrl_rd[CTRL_AFS_LSB +: 5] = cfg_q.afs;
      wmerge = tlsg_merge(ctrl_rd);
   end

   // Registers; limits saturate at range top
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lims_q <= {LIM_DEFAULT, LIM_DEFAULT, LIM_DEFAULT, LIM_DEFAULT};  // see RQ2
         cfg_q <= '{afs: 5'h00, sps: SPS_DEC1, duty_vt: 1'b1, method: METHOD_VF};  // see RQ12
         gain_q <= GAIN_DEFAULT;
         stall_lvl_q <= CEIL_VT;
         stall_lvl_set_q <= 1'b0;
      end else if (aw_q && w_q) begin
         case (awaddr_q)
            ADDR_FWD_DRV: lims_q.fwd_drv <= sat300(tlsg_merge(lims_q.fwd_drv));  // see RQ2
            ADDR_REV_DRV: lims_q.rev_drv <= sat300(tlsg_merge(lims_q.rev_drv));
            ADDR_FWD_RGN: lims_q.fwd_rgn <= sat300(tlsg_merge(lims_q.fwd_rgn));
            ADDR_REV_RGN: lims_q.rev_rgn <= sat300(tlsg_merge(lims_q.rev_rgn));
            ADDR_CTRL: begin
               cfg_q.afs <= wmerge[CTRL_AFS_LSB +: 5];
               cfg_q.sps <= wmerge[CTRL_SPS_LSB +: 2];
               cfg_q.duty_vt <= wmerge[CTRL_DUTY_BIT];
               cfg_q.method <= wmerge[CTRL_METHOD_LSB +: 2];
            end
            ADDR_STALL: begin
               stall_lvl_q <= tlsg_merge(stall_lvl_q);
               stall_lvl_set_q <= 1'b1;
            end
            ADDR_GAIN: gain_q <= tlsg_merge(gain_q);
            default: ;
         endcase
      end
   end

   // Read channel: one cycle to answer, unmapped reads zero with DECERR
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case (s_axi_araddr)
            ADDR_FWD_DRV: s_axi_rdata <= {16'h0000, lims_q.fwd_drv};
            ADDR_REV_DRV: s_axi_rdata <= {16'h0000, lims_q.rev_drv};
            ADDR_FWD_RGN: s_axi_rdata <= {16'h0000, lims_q.fwd_rgn};
            ADDR_REV_RGN: s_axi_rdata <= {16'h0000, lims_q.rev_rgn};
            ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_rd};
            ADDR_STALL: s_axi_rdata <= {16'h0000, stall_lvl_param};
            ADDR_GAIN: s_axi_rdata <= {16'h0000, gain_q};
            ADDR_STATUS: s_axi_rdata <= {16'h0000, eff_lim[11:0], clamp_q, stall_accel, stall_decel, 1'b0};
            ADDR_TORQ_OUT: s_axi_rdata <= {16'h0000, torque_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b11;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Analog limit: 4 mA is 0, 20 mA is 100 percent, times gain in 0.1 percent
   always_comb begin
      ana_ok = analog_ua > AIN_ZERO_UA;
      // Wide product: full input times a large gain must not wrap
      ana_prod = ana_ok ? 48'(analog_ua - AIN_ZERO_UA) * 48'h64 * 48'(gain_q) : 48'h0;  // see RQ4
      ana_pct = 16'(ana_prod / (48'(AIN_SPAN_UA) * 48'(GAIN_ONE)));  // see RQ8
   end

   // Parameter limit by quadrant, analog limit by function code, duty ceiling
   always_comb begin
      olv = cfg_q.method == METHOD_OLV;
      fwd = !torque_in[15];
      abs_t = fwd ? torque_in : 16'(-torque_in);  // see RQ17
      if (fwd) par_lim = regen ? lims_q.fwd_rgn : lims_q.fwd_drv;
      else par_lim = regen ? lims_q.rev_rgn : lims_q.rev_drv;
      case (cfg_q.afs)
         AFS_POS: use_ana = fwd;  // see RQ6
         AFS_NEG: use_ana = !fwd;  // see RQ3
         AFS_REGEN: use_ana = regen;
         AFS_BOTH: use_ana = 1'b1;
         default: use_ana = 1'b0;
      endcase
      ceil_lim = cfg_q.duty_vt ? CEIL_VT : CEIL_CT;
      eff_lim = par_lim < ceil_lim ? par_lim : ceil_lim;  // see RQ5
      if (use_ana && ana_pct < eff_lim) eff_lim = ana_pct;
   end

   // Clamp torque magnitude, only in open-loop vector
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         torque_q <= 16'sh0000;
         clamp_q <= 1'b0;
      end else if (olv && abs_t > eff_lim) begin
         torque_q <= fwd ? eff_lim : 16'(-eff_lim);  // see RQ1
         clamp_q <= 1'b1;  // see RQ7
      end else begin
         torque_q <= torque_in;
         clamp_q <= 1'b0;
      end
   end
   assign torque_out = torque_q;
   assign speed_ctrl_hold = clamp_q;  // see RQ7

   // Stall level default follows duty until written, clipped to range
   always_comb begin
      stall_lvl_param = stall_lvl_set_q ? stall_lvl_q : (cfg_q.duty_vt ? CEIL_VT : CEIL_CT);  // see RQ14
      if (stall_lvl_param < STALL_MIN) stall_lvl_param = STALL_MIN;  // see RQ13
      if (stall_lvl_param > STALL_MAX) stall_lvl_param = STALL_MAX;
      stall_lvl_eff = (cfg_q.afs == AFS_STALL && ana_pct < stall_lvl_param) ? ana_pct : stall_lvl_param;  // see RQ15
   end

   tlsg_stall #(.QUAL_CYC(QUAL_CYC)) u_stall (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(cfg_q.method != METHOD_OLV && cfg_q.sps != SPS_OFF),  // see RQ9
      .level(stall_lvl_eff),
      .current(current_in),
      .decel(stall_decel),
      .accel(stall_accel),
      .state(sg_state)
   );
   assign stall_use_decel_two = cfg_q.sps == SPS_DEC2;  // see RQ12

   property p_no_clamp_off_olv;
      @(posedge aclk) disable iff (!aresetn) !olv |=> (torque_out == $past(torque_in) && !speed_ctrl_hold);
   endproperty
   a_no_clamp_off_olv: assert property (p_no_clamp_off_olv) else $error("Torque clamped outside OLV");  // see RQ1
   property p_clamp_bound;
      @(posedge aclk) disable iff (!aresetn) (olv && abs_t > eff_lim) |=> (torque_out == $past(fwd ? eff_lim : 16'(-eff_lim)));
   endproperty
   a_clamp_bound: assert property (p_clamp_bound) else $error("Clamp value wrong");  // see RQ17
   property p_ceiling;
      @(posedge aclk) disable iff (!aresetn) eff_lim <= (cfg_q.duty_vt ? CEIL_VT : CEIL_CT);
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("Limit above duty ceiling");  // see RQ5
   property p_hold_with_clamp;
      @(posedge aclk) disable iff (!aresetn) speed_ctrl_hold |-> $past(olv && abs_t > eff_lim);
   endproperty
   a_hold_with_clamp: assert property (p_hold_with_clamp) else $error("Hold without clamp");  // see RQ7
   property p_no_stall_olv;
      @(posedge aclk) disable iff (!aresetn) (olv ##1 olv) |-> !stall_decel;
   endproperty
   a_no_stall_olv: assert property (p_no_stall_olv) else $error("Stall guard active in OLV");  // see RQ9
   property p_lim_range;
      @(posedge aclk) disable iff (!aresetn) lims_q.fwd_drv <= LIM_MAX && lims_q.rev_drv <= LIM_MAX
         && lims_q.fwd_rgn <= LIM_MAX && lims_q.rev_rgn <= LIM_MAX;
   endproperty
   a_lim_range: assert property (p_lim_range) else $error("Torque limit above range");  // see RQ2
   property p_stall_range;
      @(posedge aclk) disable iff (!aresetn) stall_lvl_param >= STALL_MIN && stall_lvl_param <= STALL_MAX;
   endproperty
   a_stall_range: assert property (p_stall_range) else $error("Stall level out of range");  // see RQ13
   property p_accel_after_decel;
      @(posedge aclk) disable iff (!aresetn) $rose(stall_accel) |-> $past(stall_decel);
   endproperty
   a_accel_after_decel: assert property (p_accel_after_decel) else $error("Reaccel without decel");  // see RQ11
   property p_write_resp;
      @(posedge aclk) disable iff (!aresetn) (aw_q && w_q) |=> s_axi_bvalid;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("No write response");
   c_clamp: cover property (@(posedge aclk) disable iff (!aresetn) speed_ctrl_hold);
   c_ana: cover property (@(posedge aclk) disable iff (!aresetn) use_ana && ana_pct < par_lim && olv);
   c_decel_to_accel: cover property (@(posedge aclk) disable iff (!aresetn)
      sg_state == TLSG_ACCEL && $past(sg_state) == TLSG_DECEL);
endmodule : tlsg_top

// >>> hdl/tlsg_pkg.sv
// Package for the torque limit and stall guard block: register map, field layouts, defaults, timing.
// Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus.
package tlsg_pkg;
   // Clock and timing
   localparam int CLK_MHZ = 125;
   localparam int STALL_QUAL_MS = 100;
   localparam int STALL_QUAL_CYC = STALL_QUAL_MS * 1000 * CLK_MHZ;
   // Register byte offsets
   localparam logic [7:0] ADDR_FWD_DRV = 8'h00;
   localparam logic [7:0] ADDR_REV_DRV = 8'h04;
   localparam logic [7:0] ADDR_FWD_RGN = 8'h08;
   localparam logic [7:0] ADDR_REV_RGN = 8'h0C;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [7:0] ADDR_STALL = 8'h14;
   localparam logic [7:0] ADDR_GAIN = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_TORQ_OUT = 8'h20;
   // CTRL field positions
   localparam int CTRL_METHOD_LSB = 0;  // 2 bits
   localparam int CTRL_DUTY_BIT = 2;    // duty rating select
   localparam int CTRL_SPS_LSB = 4;     // 2 bits stall prevention select
   localparam int CTRL_AFS_LSB = 8;     // 5 bits analog function select
   // Control methods
   localparam logic [1:0] METHOD_VF = 2'h0;
   localparam logic [1:0] METHOD_VF_PG = 2'h1;
   localparam logic [1:0] METHOD_OLV = 2'h2;
   // Analog function codes
   localparam logic [4:0] AFS_STALL = 5'h08;
   localparam logic [4:0] AFS_POS = 5'h0A;
   localparam logic [4:0] AFS_NEG = 5'h0B;
   localparam logic [4:0] AFS_REGEN = 5'h0C;
   localparam logic [4:0] AFS_BOTH = 5'h0F;
   // Limits in percent
   localparam logic [15:0] LIM_DEFAULT = 16'h00C8;   // 200
   localparam logic [15:0] LIM_MAX = 16'h012C;       // 300
   localparam logic [15:0] CEIL_CT = 16'h0096;       // 150
   localparam logic [15:0] CEIL_VT = 16'h0078;       // 120
   localparam logic [15:0] STALL_MIN = 16'h001E;     // 30
   localparam logic [15:0] STALL_MAX = 16'h00C8;     // 200
   localparam logic [15:0] STALL_HYST = 16'h0002;    // 2
   localparam logic [15:0] GAIN_DEFAULT = 16'h03E8;  // 100.0 percent in 0.1 steps
   localparam logic [15:0] GAIN_ONE = 16'h03E8;
   // Analog input: 4 to 20 mA in microamps
   localparam logic [15:0] AIN_ZERO_UA = 16'h0FA0;   // 4000
   localparam logic [15:0] AIN_SPAN_UA = 16'h3E80;   // 16000
   localparam logic [1:0] SPS_OFF = 2'h0;
   localparam logic [1:0] SPS_DEC1 = 2'h1;
   localparam logic [1:0] SPS_DEC2 = 2'h2;
   // Stall guard states
   typedef enum logic [1:0] {
      TLSG_RUN = 2'b00,
      TLSG_DECEL = 2'b01,
      TLSG_ACCEL = 2'b10
   } tlsg_state_t;
   // Control configuration carried together
   typedef struct packed {
      logic [4:0] afs;
      logic [1:0] sps;
      logic duty_vt;
      logic [1:0] method;
   } tlsg_cfg_t;
   // Four quadrant torque limits
   typedef struct packed {
      logic [15:0] fwd_drv;
      logic [15:0] rev_drv;
      logic [15:0] fwd_rgn;
      logic [15:0] rev_rgn;
   } tlsg_lims_t;
endpackage : tlsg_pkg

// >>> hdl/tlsg_stall.sv
// Stall guard: qualifies overcurrent for a set time and steers decel and reaccel.
// Assumes current and level in percent of rated current, on the aclk domain.
`timescale 1ns/1ns
module tlsg_stall import tlsg_pkg::*; #(
   parameter int QUAL_CYC = STALL_QUAL_CYC
) (
   input wire logic aclk,            // Clock
   input wire logic aresetn,         // Sync reset, active low
   input wire logic enable,          // V/f method and select nonzero
   input wire logic [15:0] level,    // Effective stall level, percent
   input wire logic [15:0] current,  // Output current, percent
   output logic decel,               // Lower output frequency
   output logic accel,               // Reaccelerate toward command
   output tlsg_state_t state         // Guard state
);
   logic [31:0] qual_q;
   tlsg_state_t state_q;
   logic over;
   logic under;

   // Compare current against level and level minus hysteresis
   assign over = current > level;
   assign under = ({16'h0000, current} + {16'h0000, STALL_HYST}) <= {16'h0000, level};

   // Qualification counter restarts whenever current drops to level
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable || !over) begin
         qual_q <= 32'h0000_0000;  // see RQ16
      end else if (qual_q < 32'(QUAL_CYC)) begin
         qual_q <= qual_q + 32'h0000_0001;  // see RQ10
      end
   end

   // Decel after qualification, reaccel once below hysteresis band
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         state_q <= TLSG_RUN;
      end else begin
         case (state_q)
            TLSG_RUN: if (qual_q >= 32'(QUAL_CYC)) state_q <= TLSG_DECEL;  // see RQ10
            TLSG_DECEL: if (under) state_q <= TLSG_ACCEL;  // see RQ11
            TLSG_ACCEL: if (qual_q >= 32'(QUAL_CYC)) state_q <= TLSG_DECEL;
            default: state_q <= TLSG_RUN;
         endcase
      end
   end

   assign decel = state_q == TLSG_DECEL;
   assign accel = state_q == TLSG_ACCEL;
   assign state = state_q;

   property p_decel_after_qual;
      @(posedge aclk) disable iff (!aresetn) (state_q == TLSG_RUN && enable && qual_q >= 32'(QUAL_CYC)) |=> decel;
   endproperty
   a_decel_after_qual: assert property (p_decel_after_qual) else $error("No decel after qualification");  // see RQ10
   property p_reaccel;
      @(posedge aclk) disable iff (!aresetn) (decel && enable && under) |=> accel;
   endproperty
   a_reaccel: assert property (p_reaccel) else $error("No reaccel below band");  // see RQ11
   property p_qual_restart;
      @(posedge aclk) disable iff (!aresetn) !over |=> qual_q == 32'h0;
   endproperty
   a_qual_restart: assert property (p_qual_restart) else $error("Timer not restarted");  // see RQ16
   c_decel: cover property (@(posedge aclk) disable iff (!aresetn) $rose(decel));
   c_accel: cover property (@(posedge aclk) disable iff (!aresetn) $rose(accel));
endmodule : tlsg_stall

// >>> sim/tlsg_motor.sv
// Motor and load model: output current follows the load and sheds while frequency is lowered.
// Assumes the guard's decel and accel levels arrive on the same aclk.
`timescale 1ns/1ns
module tlsg_motor (
   input wire logic aclk,          // Clock
   input wire logic aresetn,       // Sync reset, active low
   input wire logic [15:0] load,   // Load current demand, percent
   input wire logic decel,         // Frequency being lowered
   input wire logic accel,         // Frequency rising again
   output logic [15:0] current     // Output current, percent
);
   // Slowing sheds 1 percent a cycle; reacceleration holds the reduced current
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         current <= 16'h0000;
      end else if (decel) begin
         if (current != 16'h0000) current <= current - 16'h0001;
      end else if (!accel) begin
         current <= load;
      end
   end
endmodule : tlsg_motor

// >>> sim/tb_top.sv
// Bench for the torque limit and stall guard: register, clamp and stall sequences.
// Assumes the design package and motor model; the guard runs with a short qualification time.
`timescale 1ns/1ns
module tb_top import tlsg_pkg::*;;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hold, dec, acc, dtwo, regen = 1'b0;
   logic [1:0] bresp, rresp, rr;
   logic signed [15:0] torque = 16'sh0000, tq_out;
   logic [15:0] analog = 16'h0000, load = 16'h0000, cur, c;
   logic [1:0] mt[5] = '{METHOD_VF, METHOD_VF, METHOD_VF, METHOD_OLV, METHOD_VF_PG};
   logic [1:0] sp[5] = '{SPS_DEC1, SPS_DEC2, SPS_OFF, SPS_DEC1, SPS_DEC1};
   int err_count = 0, n_checks = 0, n, i;

   // Free-running 125 MHz clock
   initial forever #4 aclk = ~aclk;

   tlsg_top #(.QUAL_CYC(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .torque_in(torque), .regen(regen), .current_in(cur), .analog_ua(analog),
      .torque_out(tq_out), .speed_ctrl_hold(hold), .stall_decel(dec), .stall_accel(acc),
      .stall_use_decel_two(dtwo));

   tlsg_motor i_motor (.aclk(aclk), .aresetn(aresetn), .load(load), .decel(dec), .accel(acc),
      .current(cur));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   // AXI4-Lite write; channels held until taken, answer awaited under a bound
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40 && !tb; n++) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         if (tb) chk({30'h0, bresp}, 32'h0000_0000);
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      if (!tb) err_count++;
      if (!tb) print_verdict();
   endtask : axw

   // AXI4-Lite read; data and response sampled on the falling edge of the handshake cycle
   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40 && !tr; n++) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         rd = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      if (!tr) err_count++;
      if (!tr) print_verdict();
   endtask : axr

   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      axr(a);
      chk({16'h0000, rd[15:0]}, {16'h0000, e});
   endtask : rc

   task automatic ctl(input logic [1:0] m, input logic d, input logic [1:0] s, input logic [4:0] f);
      axw(ADDR_CTRL, {19'h0, f, 2'b00, s, 1'b0, d, m});
   endtask : ctl

   // One torque sample, checked one cycle later
   task automatic tq(input logic signed [15:0] t, input logic g, input logic signed [15:0] e,
         input logic h);
      torque <= t;
      regen <= g;
      @(posedge aclk);
      @(negedge aclk);
      chk({16'h0000, tq_out}, {16'h0000, e});
      chk({31'h0, hold}, {31'h0, h});
      @(posedge aclk);
   endtask : tq

   task automatic rst;
      aresetn <= 1'b0;
      load <= 16'h0000;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : rst

   // Count cycles until the chosen guard output rises, 40 meaning never
   task automatic wst(input logic s);
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         c = cur;
         if ((s ? acc : dec) === 1'b1) break;
         @(posedge aclk);
      end
      if (n < 40) @(posedge aclk);
   endtask : wst

   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 4; i++) rc(8'(4 * i), LIM_DEFAULT);
      rc(ADDR_CTRL, 16'h0014);
      rc(ADDR_STALL, 16'h0078);
      rc(ADDR_GAIN, GAIN_DEFAULT);
      axr(8'h24);
      chk(rd, 32'h0000_0000);
      chk({30'h0, rr}, 32'h0000_0003);
      axw(ADDR_FWD_DRV, 32'h190);
      rc(ADDR_FWD_DRV, LIM_MAX);
      ctl(METHOD_VF, 1'b0, SPS_DEC1, 5'h00);
      rc(ADDR_CTRL, 16'h0010);
      rc(ADDR_STALL, 16'h0096);
      axw(ADDR_STALL, 32'h5);
      rc(ADDR_STALL, STALL_MIN);
      $display("test registers done");
      // Quadrant limits, duty ceiling and method gating
      rst();
      ctl(METHOD_OLV, 1'b0, SPS_DEC1, 5'h00);
      axw(ADDR_FWD_DRV, 32'h64);
      axw(ADDR_FWD_RGN, 32'h32);
      tq(250, 1'b0, 100, 1'b1);
      tq(-250, 1'b0, -150, 1'b1);
      tq(250, 1'b1, 50, 1'b1);
      tq(-250, 1'b1, -150, 1'b1);
      rc(ADDR_TORQ_OUT, 16'hFF6A);
      rc(ADDR_STATUS, 16'h0968);
      tq(20, 1'b0, 20, 1'b0);
      ctl(METHOD_OLV, 1'b1, SPS_DEC1, 5'h00);
      tq(-250, 1'b0, -120, 1'b1);
      ctl(METHOD_VF, 1'b0, SPS_DEC1, 5'h00);
      tq(250, 1'b0, 250, 1'b0);
      $display("test clamp done");
      // Analog limits for each function code
      axw(ADDR_FWD_DRV, 32'h12C);
      axw(ADDR_FWD_RGN, 32'h12C);
      ctl(METHOD_OLV, 1'b0, SPS_DEC1, AFS_POS);
      analog <= 16'd20000;
      tq(250, 1'b0, 100, 1'b1);
      analog <= 16'd12000;
      tq(250, 1'b0, 50, 1'b1);
      axw(ADDR_GAIN, 32'd1500);
      tq(250, 1'b1, 75, 1'b1);
      tq(-250, 1'b0, -150, 1'b1);
      ctl(METHOD_OLV, 1'b0, SPS_DEC1, AFS_NEG);
      tq(-250, 1'b0, -75, 1'b1);
      tq(250, 1'b0, 150, 1'b1);
      ctl(METHOD_OLV, 1'b0, SPS_DEC1, AFS_REGEN);
      tq(-250, 1'b1, -75, 1'b1);
      tq(-250, 1'b0, -150, 1'b1);
      ctl(METHOD_OLV, 1'b0, SPS_DEC1, AFS_BOTH);
      tq(-250, 1'b0, -75, 1'b1);
      tq(250, 1'b0, 75, 1'b1);
      analog <= 16'd3000;
      tq(250, 1'b0, 0, 1'b1);
      $display("test analog done");
      // Stall guard per select and method
      for (i = 0; i < 5; i++) begin
         rst();
         ctl(mt[i], 1'b1, sp[i], 5'h00);
         chk({31'h0, dtwo}, {31'h0, i == 1});
         load <= 16'd130;
         wst(1'b0);
         chk({31'h0, n >= 18 && n <= 24}, {31'h0, i < 2 || i == 4});
      end
      // Timer restart on a dip, then reacceleration threshold
      rst();
      axw(ADDR_STALL, 32'd100);
      load <= 16'd110;
      repeat (15) @(posedge aclk);
      load <= 16'd90;
      @(posedge aclk);
      load <= 16'd110;
      wst(1'b0);
      chk({31'h0, n >= 18 && n <= 24}, 32'h1);
      rc(ADDR_STATUS, 16'h0782);
      wst(1'b1);
      chk({16'h0, c}, 32'd97);
      rc(ADDR_STATUS, 16'h0784);
      // Analog stall level below the parameter
      rst();
      ctl(METHOD_VF, 1'b1, SPS_DEC1, AFS_STALL);
      axw(ADDR_STALL, 32'd100);
      load <= 16'd60;
      wst(1'b0);
      chk({31'h0, n >= 18 && n <= 24}, 32'h1);
      $display("test stall done");
      print_verdict();
   end
endmodule : tb_top
